/* hw/adc_event_unit.sv */
// ADC second-level event unit: DMA result counter, pending flags and enables
//
// Notes on behaviour
// [R1] A read-only 13-bit count tells how many results the DMA has stored.
// [R2] Bit 4 of the pending flags is set on a DMA buffer overflow.
// [R3] Bit 3 of the pending flags is set when gain correction saturates.
// [R4] Bit 2 of the pending flags is set when the DMA buffer fills completely.
// [R5] Bit 1 of the pending flags is set when the buffer reaches half full.
// [R6] Bit 0 of the pending flags is set when a new conversion result arrives.
// [R7] Each source has a read-write enable bit at its flag's bit position.
// [R8] All sources combine into one request for the top-level vectored controller.
// [R9] Software uses the top-level enable for the whole unit, second-level per source.
// [R10] Flags are set only by hardware events, never by a software write.
// [R11] A result ready while DMA is idle is an overflow; DMA reset clears status.
// [R12] Buffer size counts 16-bit results; full and half compare count to it.
// [R13] Flags set regardless of enables; request high while an enabled flag is set.
// [R14] Count clears on DMA reset, on a new load, and on wrap in auto-wrap mode.
`include "adc_evt_consts.svh"

module adc_event_unit #(
    parameter int COUNT_W = `ADC_EVT_COUNT_W,
    parameter int ADDR_W = 32
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // DMA control from the DMA configuration logic
    input wire logic [COUNT_W-1:0] i_buffer_size,
    input wire logic i_autowrap,
    input wire logic i_dma_load,
    input wire logic i_dma_reset,
    // Hardware events from the conversion datapath
    input wire logic i_result_ready,
    input wire logic i_gain_saturated,
    // DMA status
    output logic o_dma_active,
    output logic o_dma_overflow,
    output logic [COUNT_W-1:0] o_dma_results_written,
    output logic o_dma_write,
    // Request to the top-level vectored controller
    output logic o_irq
);

    // Register decode
    wire logic hit_pending;
    wire logic hit_enable;
    wire logic hit_count;
    wire logic wr_pending;
    wire logic wr_enable;

    assign hit_pending = (i_addr == ADDR_W'(`ADC_EVT_PENDING_ADDR));
    assign hit_enable = (i_addr == ADDR_W'(`ADC_EVT_ENABLE_ADDR));
    assign hit_count = (i_addr == ADDR_W'(`ADC_EVT_COUNT_ADDR));
    assign wr_pending = i_wr & hit_pending;
    assign wr_enable = i_wr & hit_enable;

    // DMA sequencer state
    adc_evt_pkg::dma_state_e state_r;
    adc_evt_pkg::dma_state_e state_nxt;
    logic [COUNT_W-1:0] count_r;
    logic [COUNT_W-1:0] count_nxt;
    logic overflow_r;
    logic overflow_nxt;
    logic write_r;
    logic write_nxt;

    // Enables, interrupt request and read data
    adc_evt_pkg::evt_vec_t enable_r;
    adc_evt_pkg::evt_vec_t enable_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // Event conditions
    wire logic running;
    wire logic take_result;
    wire logic [COUNT_W-1:0] count_inc;
    wire logic [COUNT_W-1:0] half_point;
    wire logic reach_full;
    wire logic reach_half;
    wire logic ev_overflow;
    wire logic ev_full;
    wire logic ev_half;

    assign running = (state_r == adc_evt_pkg::DMA_RUN);
    assign take_result = running & i_result_ready & ~i_dma_reset & ~i_dma_load;
    assign count_inc = count_r + COUNT_W'(1);
    // Sizes are counted in results, not bytes
    assign half_point = i_buffer_size >> 1; // [R12]
    assign reach_full = (count_inc == i_buffer_size); // [R12]
    assign reach_half = (half_point != '0) && (count_inc == half_point); // [R12]
    // A result with nobody to store it is lost and reported
    assign ev_overflow = i_result_ready & ~running; // [R11]
    assign ev_full = take_result & reach_full;
    assign ev_half = take_result & reach_half;

    // Flag bank; software writes can only clear, never set
    event_flag_if flag_bus ();

    assign flag_bus.set_evt[`ADC_EVT_BIT_OVERFLOW] = ev_overflow; // [R2]
    assign flag_bus.set_evt[`ADC_EVT_BIT_SATURATION] = i_gain_saturated; // [R3]
    assign flag_bus.set_evt[`ADC_EVT_BIT_FULL] = ev_full; // [R4]
    assign flag_bus.set_evt[`ADC_EVT_BIT_HALF] = ev_half; // [R5]
    assign flag_bus.set_evt[`ADC_EVT_BIT_NEW_RESULT] = i_result_ready; // [R6]
    assign flag_bus.clr_evt = wr_pending ? i_wdata[`ADC_EVT_NUM-1:0] : '0; // [R10]

    event_flag_bank #(
        .NUM(`ADC_EVT_NUM)
    ) u_flags (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .flags(flag_bus.bank)
    );

    // DMA sequencer; reset beats load, load beats a result in the same cycle
    always_comb
    begin
        state_nxt = state_r;
        count_nxt = count_r;
        overflow_nxt = overflow_r | ev_overflow; // [R11]
        write_nxt = 1'b0;
        if (i_dma_reset)
        begin
            state_nxt = adc_evt_pkg::DMA_IDLE;
            count_nxt = `ADC_EVT_COUNT_RST; // [R14]
            overflow_nxt = 1'b0; // [R11]
        end
        else if (i_dma_load)
        begin
            state_nxt = adc_evt_pkg::DMA_RUN;
            count_nxt = `ADC_EVT_COUNT_RST; // [R14]
        end
        else
        begin
            unique case (state_r)
                adc_evt_pkg::DMA_IDLE:
                begin
                    state_nxt = adc_evt_pkg::DMA_IDLE;
                end
                adc_evt_pkg::DMA_RUN:
                begin
                    if (i_result_ready)
                    begin
                        write_nxt = 1'b1;
                        count_nxt = count_inc; // [R1]
                        if (reach_full && i_autowrap)
                            count_nxt = `ADC_EVT_COUNT_RST; // [R14]
                        else if (reach_full)
                            state_nxt = adc_evt_pkg::DMA_IDLE;
                    end
                end
            endcase
        end
    end

    // Enables take the written value; reserved bits are dropped
    assign enable_nxt = wr_enable ? i_wdata[`ADC_EVT_NUM-1:0] : enable_r; // [R7]

    // One request per unit; the top-level enable lives in the far controller
    assign irq_nxt = |(flag_bus.pending & enable_r); // [R8] [R13]

    // Read mux; unmapped addresses and idle cycles answer zero
    always_comb
    begin
        rdata_nxt = '0;
        if (i_rd && hit_pending)
            rdata_nxt[`ADC_EVT_NUM-1:0] = flag_bus.pending;
        else if (i_rd && hit_enable)
            rdata_nxt[`ADC_EVT_NUM-1:0] = enable_r; // [R7]
        else if (i_rd && hit_count)
            rdata_nxt[COUNT_W-1:0] = count_r; // [R1]
    end

    // Sequencer registers
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            state_r <= adc_evt_pkg::DMA_IDLE;
            count_r <= `ADC_EVT_COUNT_RST;
            overflow_r <= 1'b0;
            write_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            overflow_r <= overflow_nxt;
            write_r <= write_nxt;
        end
    end

    // Software-facing registers
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            enable_r <= `ADC_EVT_ENABLE_RST;
            irq_r <= 1'b0;
            rdata_r <= '0;
        end
        else
        begin
            enable_r <= enable_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Every output straight from a flop
    assign o_rdata = rdata_r;
    assign o_dma_active = running;
    assign o_dma_overflow = overflow_r;
    assign o_dma_results_written = count_r;
    assign o_dma_write = write_r;
    assign o_irq = irq_r; // [R8]

endmodule : adc_event_unit

/* hw/adc_evt_consts.svh */
// Offsets, field positions, reset values and widths of the ADC event block
`ifndef ADC_EVT_CONSTS_SVH
`define ADC_EVT_CONSTS_SVH

// Register byte addresses
`define ADC_EVT_PENDING_ADDR 32'h4000a810
`define ADC_EVT_ENABLE_ADDR 32'h4000a850
`define ADC_EVT_COUNT_ADDR 32'h4000d024

// Reset values
`define ADC_EVT_PENDING_RST 5'h00
`define ADC_EVT_ENABLE_RST 5'h00
`define ADC_EVT_COUNT_RST 13'h0000

// Event bit positions, shared by pending flags and enables
`define ADC_EVT_BIT_OVERFLOW 4
`define ADC_EVT_BIT_SATURATION 3
`define ADC_EVT_BIT_FULL 2
`define ADC_EVT_BIT_HALF 1
`define ADC_EVT_BIT_NEW_RESULT 0

// Field widths
`define ADC_EVT_NUM 5
`define ADC_EVT_COUNT_W 13
`define ADC_EVT_DATA_W 32

`endif

/* hw/adc_evt_pkg.sv */
// Types shared by the ADC event block
package adc_evt_pkg;

    // DMA sequencer states
    typedef enum logic {
        DMA_IDLE,
        DMA_RUN
    } dma_state_e;

    // One bit per event source
    typedef logic [4:0] evt_vec_t;

endpackage : adc_evt_pkg

/* hw/event_flag_bank.sv */
// Bank of sticky pending flags, set by hardware and cleared by writing one
`include "adc_evt_consts.svh"

module event_flag_bank #(
    parameter int NUM = `ADC_EVT_NUM
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    event_flag_if.bank flags
);

    genvar g;
    generate
        for (g = 0; g < NUM; g++)
        begin : g_flag
            logic flag_r;
            logic flag_nxt;

            // Set beats clear so an event landing in the clearing cycle survives
            assign flag_nxt = flags.set_evt[g] | (flag_r & ~flags.clr_evt[g]); // [R13]

            always_ff @(posedge i_clk)
            begin
                if (!i_rstn)
                    flag_r <= 1'b0;
                else
                    flag_r <= flag_nxt;
            end

            assign flags.pending[g] = flag_r;
        end
    endgenerate

endmodule : event_flag_bank

/* hw/event_flag_if.sv */
// Carrier between the top and the sticky flag bank
interface event_flag_if;
    adc_evt_pkg::evt_vec_t set_evt;
    adc_evt_pkg::evt_vec_t clr_evt;
    adc_evt_pkg::evt_vec_t pending;

    modport bank
    (
        input set_evt,
        input clr_evt,
        output pending
    );
    modport user
    (
        output set_evt,
        output clr_evt,
        input pending
    );
endinterface : event_flag_if

/* test/adc_dma_count_and_event_flags_test.sv */
// Self-checking bench for the ADC event unit
`include "adc_evt_consts.svh"

module adc_dma_count_and_event_flags_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] pend_a = `ADC_EVT_PENDING_ADDR;
    localparam logic [31:0] ena_a = `ADC_EVT_ENABLE_ADDR;
    localparam logic [31:0] cnt_a = `ADC_EVT_COUNT_ADDR;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [31:0] i_addr = 32'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [12:0] i_buffer_size = 13'h0004;
    logic i_autowrap = 1'b0;
    logic [3:0] ev = 4'h0; // Reset, load, saturation, result
    logic [31:0] o_rdata;
    logic [12:0] cnt;
    logic act, ovf, dwr, irq, top_pending;
    logic line_en = 1'b1; // Whole-peripheral gate at the far controller
    int err_total = 0;
    int cmp_count = 0;

    adc_event_unit uut (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_buffer_size, .i_autowrap, .i_dma_load(ev[2]), .i_dma_reset(ev[3]),
        .i_result_ready(ev[0]), .i_gain_saturated(ev[1]), .o_dma_active(act),
        .o_dma_overflow(ovf), .o_dma_results_written(cnt), .o_dma_write(dwr), .o_irq(irq));
    top_vector_model far_end (.i_clk, .i_rstn, .i_req(irq), .i_line_enable(line_en),
        .o_pending(top_pending));

    initial forever #25 i_clk = ~i_clk;

    task close_out;
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(what, o_rdata, exp);
    endtask : rd

    task pulse(input logic [3:0] v);
        @(posedge i_clk);
        ev <= v;
        @(posedge i_clk);
        ev <= 4'h0;
        #1;
    endtask : pulse

    task t_regs;
        rd(ena_a, 32'h0, "enable rst");
        rd(cnt_a, 32'h0, "count rst");
        wr(ena_a, 32'hffff_ffff);
        rd(ena_a, 32'h1f, "enable rw");
        rd(32'h4000_a814, 32'h0, "unmapped");
        wr(cnt_a, 32'h55);
        rd(cnt_a, 32'h0, "count ro");
        wr(ena_a, 32'h0);
        wr(pend_a, 32'h1f);
        rd(pend_a, 32'h0, "no soft set");
    endtask : t_regs

    task t_irq;
        pulse(4'b0010);
        rd(pend_a, 32'h08, "saturation");
        chk("masked irq", irq, 1'b0);
        wr(ena_a, 32'h08);
        @(posedge i_clk);
        #1;
        chk("irq", irq, 1'b1);
        @(posedge i_clk);
        #1;
        chk("top line", top_pending, 1'b1);
        @(posedge i_clk);
        line_en <= 1'b0;
        @(posedge i_clk);
        #1;
        chk("top gated", top_pending, 1'b0);
        @(posedge i_clk);
        line_en <= 1'b1;
        wr(pend_a, 32'h08);
        rd(pend_a, 32'h0, "cleared");
        chk("irq low", irq, 1'b0);
    endtask : t_irq

    task t_dma;
        pulse(4'b0001);
        chk("overflow", ovf, 1'b1);
        chk("idle no write", dwr, 1'b0);
        rd(pend_a, 32'h11, "idle result");
        pulse(4'b1000);
        chk("ovf cleared", ovf, 1'b0);
        wr(pend_a, 32'h1f);
        pulse(4'b0100);
        chk("active", act, 1'b1);
        pulse(4'b0001);
        chk("dma write", dwr, 1'b1);
        pulse(4'b0001);
        rd(pend_a, 32'h03, "half");
        rd(cnt_a, 32'h2, "count two");
        pulse(4'b0001);
        pulse(4'b0001);
        rd(pend_a, 32'h07, "full");
        rd(cnt_a, 32'h4, "count full");
        chk("stopped", act, 1'b0);
        wr(pend_a, 32'h1f);
        @(posedge i_clk);
        i_autowrap <= 1'b1;
        i_buffer_size <= 13'h0002;
        pulse(4'b0100);
        pulse(4'b0001);
        pulse(4'b0001);
        rd(cnt_a, 32'h0, "wrap count");
        chk("wrap active", act, 1'b1);
        rd(pend_a, 32'h07, "wrap flags");
    endtask : t_dma

    // Watchdog: the sequence needs well under 300 cycles
    initial
    begin
        repeat (2000) @(posedge i_clk);
        err_total++;
        close_out();
    end

    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_regs();
        t_irq();
        t_dma();
        close_out();
    end
endmodule : adc_dma_count_and_event_flags_test

/* test/adc_event_unit_checker.sv */
// Port-level checks of the ADC event unit
`include "adc_evt_consts.svh"

module adc_event_unit_checker #(
    parameter int COUNT_W = 13,
    parameter int ADDR_W = 32
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [COUNT_W-1:0] i_buffer_size,
    input wire logic i_autowrap,
    input wire logic i_dma_load,
    input wire logic i_dma_reset,
    input wire logic i_result_ready,
    input wire logic i_gain_saturated,
    input wire logic o_dma_active,
    input wire logic o_dma_overflow,
    input wire logic [COUNT_W-1:0] o_dma_results_written,
    input wire logic o_dma_write,
    input wire logic o_irq
);
    // A result is stored only while running and not overridden by load or reset
    wire logic take = i_result_ready && o_dma_active && !i_dma_load && !i_dma_reset;
    wire logic at_full = take && (o_dma_results_written + 1'b1 == i_buffer_size);
    wire logic cause = i_result_ready || i_gain_saturated || i_wr;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    a_result_counts: assert property (take && !at_full |=> o_dma_write &&
        o_dma_results_written == $past(o_dma_results_written) + 1'b1) else $error("count step");
    a_full_linear: assert property (at_full && !i_autowrap |=> !o_dma_active &&
        o_dma_results_written == $past(i_buffer_size)) else $error("linear full");
    a_full_wrap: assert property (at_full && i_autowrap |=>
        o_dma_active && o_dma_results_written == '0) else $error("wrap full");
    a_idle_overflow: assert property (i_result_ready && !o_dma_active && !i_dma_reset
        |=> o_dma_overflow) else $error("idle overflow");
    a_reset_clears: assert property (i_dma_reset |=> !o_dma_overflow && !o_dma_active
        && o_dma_results_written == '0) else $error("dma reset");
    a_load_starts: assert property (i_dma_load && !i_dma_reset |=> o_dma_active &&
        o_dma_results_written == '0) else $error("dma load");
    a_count_read: assert property (i_rd && i_addr == `ADC_EVT_COUNT_ADDR |=>
        o_rdata == 32'($past(o_dma_results_written))) else $error("count read");
    a_rdata_quiet: assert property (!i_rd |=> o_rdata == 32'h0) else $error("rdata");
    a_irq_cause: assert property ($rose(o_irq) |-> $past(cause, 2)) else $error("irq");
    a_write_cause: assert property (o_dma_write |-> $past(i_result_ready))
        else $error("dma write");

    c_wrap: cover property (at_full && i_autowrap);
    c_linear: cover property (at_full && !i_autowrap);
    c_irq: cover property ($rose(o_irq));
endmodule : adc_event_unit_checker

bind adc_event_unit adc_event_unit_checker #(.COUNT_W(COUNT_W), .ADDR_W(ADDR_W)) chk (
    .i_clk, .i_rstn, .i_addr, .i_wr, .i_rd, .o_rdata, .i_buffer_size, .i_autowrap,
    .i_dma_load, .i_dma_reset, .i_result_ready, .i_gain_saturated, .o_dma_active,
    .o_dma_overflow, .o_dma_results_written, .o_dma_write, .o_irq);

/* test/top_vector_model.sv */
// Behavioural model of one input line of the top-level vectored controller
module top_vector_model (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_req,
    input wire logic i_line_enable,
    output logic o_pending
);
    // Whole-peripheral gate only; single sources are chosen in the unit itself
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            o_pending <= 1'b0;
        else
            o_pending <= i_req && i_line_enable;
    end
endmodule : top_vector_model
